// ---- logic/apat_pkg.sv ----
// Shared constants and types of the asynchronous panel access timing block
`default_nettype none
package apat_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CFG_W = 8;
   localparam int PT_W = 10;
   localparam int DATA_W = 8;
   localparam int BIT_W = 3;
   // ----------------------------------------------------------------
   // Counts in half interface clocks (one link clock each)
   // ----------------------------------------------------------------
   localparam logic [PT_W-1:0] MIN_SIZE_TICKS = 10'h002;
   localparam logic [1:0] GAP_TICKS = 2'h2;
   localparam logic [BIT_W-1:0] SER_BIT_LAST = 3'h7;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [PT_W-1:0] PT_RST = 10'h000;
   // ----------------------------------------------------------------
   // Port modes and link states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      APAT_PAR80, APAT_PAR68, APAT_SER3, APAT_SER4, APAT_SER5A, APAT_SER5B
   } apat_mode_e;
   typedef enum logic [1:0] {APAT_IDLE, APAT_RUN, APAT_GAP} apat_state_e;
endpackage
`default_nettype wire

// ---- logic/apat_sync.sv ----
// Two flip-flop level synchroniser, one per bit
`default_nettype none
module apat_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // apat_sync
`default_nettype wire

// ---- logic/apat_ceil.sv ----
// Rounds a programmed point to half interface clock ticks
`default_nettype none
module apat_ceil
   import apat_pkg::*;
(
   // Operands
   input wire logic [apat_pkg::CFG_W-1:0] value,
   input wire logic [apat_pkg::CFG_W-1:0] period,
   input wire logic half_res,
   // Result in half ticks
   output logic [apat_pkg::PT_W-1:0] ticks
);
   logic [PT_W-1:0] num;
   logic [PT_W-1:0] den;
   logic [PT_W-1:0] quo;

   // Zero period treated as one so the divider never stalls on zero
   assign num = half_res ? {1'b0, value, 1'b0} : {2'b00, value};
   assign den = (period == '0) ? 10'h001 : {2'b00, period};
   assign quo = (num + den - 10'h001) / den;
   // Full-clock results are doubled into half ticks
   assign ticks = half_res ? quo : {quo[PT_W-2:0], 1'b0};
endmodule // apat_ceil
`default_nettype wire

// ---- logic/apat_top.sv ----
// Access timing generator for a parallel or serial panel port
//
// Behaviour
// - Write access lasts write size rounded up to whole interface clocks.
// - Read access lasts its own programmed read size, rounded likewise.
// - Chip select asserts at its point rounded up to half clocks.
// - Chip select releases at its rounded release point.
// - Register select asserts at its own half-clock rounded point.
// - Register select releases at its own rounded release point.
// - Read strobe spans rounded assert to release during reads.
// - Write strobe spans rounded assert to release during 80-style writes; 68k-style holds it high over reads.
// - Read data sampled at operand rounded up to whole clocks.
// - Serial port offers 3-wire, 4-wire and two 5-wire variants.
// - 5-wire variant one frames select per bit, variant two per frame.
// - Four serial outputs and one input, arrangement chosen by mode.
// - 3-wire keeps split data lines plus an output enable.
// - 4-wire uses dedicated in and out lines, no direction switching.
// - 5-wire drives a dedicated register select output.
// - Wait reacts two half interface clocks after its synchroniser, holds off next access.
// - Single access mode idles all strobes one clock after access.
// - Parallel port supports 80-style and 68k-style signalling.
`default_nettype none
module apat_top
   import apat_pkg::*;
(
   // System clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Link clock, one period per half interface clock
   input wire logic panel_port_clock,
   // Configuration
   input wire apat_pkg::apat_mode_e bus_mode,
   input wire logic single_access_mode,
   input wire logic [apat_pkg::CFG_W-1:0] clock_period_setting,
   input wire logic [apat_pkg::CFG_W-1:0] write_access_size,
   input wire logic [apat_pkg::CFG_W-1:0] read_access_size,
   input wire logic [apat_pkg::CFG_W-1:0] cs_assert_point,
   input wire logic [apat_pkg::CFG_W-1:0] cs_release_point,
   input wire logic [apat_pkg::CFG_W-1:0] rs_assert_point,
   input wire logic [apat_pkg::CFG_W-1:0] rs_release_point,
   input wire logic [apat_pkg::CFG_W-1:0] rd_assert_point,
   input wire logic [apat_pkg::CFG_W-1:0] rd_release_point,
   input wire logic [apat_pkg::CFG_W-1:0] wr_assert_point,
   input wire logic [apat_pkg::CFG_W-1:0] wr_release_point,
   input wire logic [apat_pkg::CFG_W-1:0] read_sample_operand,
   // Access request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_is_read,
   input wire logic req_rs_value,
   input wire logic [apat_pkg::DATA_W-1:0] req_wdata,
   // Access answer
   output logic done_pulse,
   output logic [apat_pkg::DATA_W-1:0] rd_data,
   // Parallel panel pins
   output logic panel_chip_select,
   output logic register_select,
   output logic panel_rd_strobe,
   output logic panel_wr_strobe,
   output logic [apat_pkg::DATA_W-1:0] par_data_out,
   output logic par_data_oe,
   input wire logic [apat_pkg::DATA_W-1:0] par_data_in,
   input wire logic panel_wait,
   // Serial panel pins
   output logic serial_panel_clock,
   output logic serial_data_out,
   output logic serial_out_enable,
   output logic serial_register_select,
   input wire logic serial_data_in
);
   // ----------------------------------------------------------------
   // System side: request capture
   // ----------------------------------------------------------------
   logic busy_reg;
   logic req_tgl_reg;
   logic done_pulse_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic [PT_W-1:0] size_reg, cs_up_reg, cs_dn_reg, rs_up_reg, rs_dn_reg;
   logic [PT_W-1:0] st_up_reg, st_dn_reg, smp_reg;
   logic read_reg, rs_val_reg, single_reg;
   logic [DATA_W-1:0] wdata_reg;
   apat_mode_e mode_reg;
   logic [PT_W-1:0] size_t, cs_up_t, cs_dn_t, rs_up_t, rs_dn_t, st_up_t, st_dn_t, smp_t;
   logic [CFG_W-1:0] size_sel, st_up_sel, st_dn_sel;
   logic take;
   logic done_tgl_s;
   logic done_seen_reg;
   logic done_evt;
   logic done_tgl_reg;
   logic [DATA_W-1:0] rdata_hold_reg;

   // Read and write take their own size and strobe points
   assign size_sel = req_is_read ? read_access_size : write_access_size;
   assign st_up_sel = req_is_read ? rd_assert_point : wr_assert_point;
   assign st_dn_sel = req_is_read ? rd_release_point : wr_release_point;
   assign req_ready = !busy_reg;
   assign take = req_valid && !busy_reg;
   assign done_evt = done_tgl_s ^ done_seen_reg;
   assign done_pulse = done_pulse_reg;
   assign rd_data = rd_data_reg;

   apat_ceil u_size (.value(size_sel), .period(clock_period_setting), .half_res(1'b0),
      .ticks(size_t));
   apat_ceil u_csu (.value(cs_assert_point), .period(clock_period_setting), .half_res(1'b1),
      .ticks(cs_up_t));
   apat_ceil u_csd (.value(cs_release_point), .period(clock_period_setting), .half_res(1'b1),
      .ticks(cs_dn_t));
   apat_ceil u_rsu (.value(rs_assert_point), .period(clock_period_setting), .half_res(1'b1),
      .ticks(rs_up_t));
   apat_ceil u_rsd (.value(rs_release_point), .period(clock_period_setting), .half_res(1'b1),
      .ticks(rs_dn_t));
   apat_ceil u_stu (.value(st_up_sel), .period(clock_period_setting), .half_res(1'b1),
      .ticks(st_up_t));
   apat_ceil u_std (.value(st_dn_sel), .period(clock_period_setting), .half_res(1'b1),
      .ticks(st_dn_t));
   apat_ceil u_smp (.value(read_sample_operand), .period(clock_period_setting),
      .half_res(1'b0), .ticks(smp_t));

   // Access finish toggle returns from the link side
   apat_sync #(.W(1)) u_done_sync (.clk(clock), .rst_n(rst_n), .d(done_tgl_reg),
      .q(done_tgl_s));

   // Held words stay still while busy, so the link may read them freely
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_reg <= 1'b0;
         req_tgl_reg <= 1'b0;
         size_reg <= PT_RST;
         cs_up_reg <= PT_RST;
         cs_dn_reg <= PT_RST;
         rs_up_reg <= PT_RST;
         rs_dn_reg <= PT_RST;
         st_up_reg <= PT_RST;
         st_dn_reg <= PT_RST;
         smp_reg <= PT_RST;
         read_reg <= 1'b0;
         rs_val_reg <= 1'b0;
         single_reg <= 1'b0;
         wdata_reg <= DATA_RST;
         mode_reg <= APAT_PAR80;
      end
      else if (take)
      begin
         busy_reg <= 1'b1;
         req_tgl_reg <= !req_tgl_reg;
         size_reg <= (size_t < MIN_SIZE_TICKS) ? MIN_SIZE_TICKS : size_t;
         cs_up_reg <= cs_up_t;
         cs_dn_reg <= cs_dn_t;
         rs_up_reg <= rs_up_t;
         rs_dn_reg <= rs_dn_t;
         st_up_reg <= st_up_t;
         st_dn_reg <= st_dn_t;
         smp_reg <= smp_t;
         read_reg <= req_is_read;
         rs_val_reg <= req_rs_value;
         single_reg <= single_access_mode;
         wdata_reg <= req_wdata;
         mode_reg <= bus_mode;
      end
      else if (done_evt)
      begin
         busy_reg <= 1'b0;
      end
   end

   // Answer: read word is stable by the time the toggle arrives
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_seen_reg <= 1'b0;
         done_pulse_reg <= 1'b0;
         rd_data_reg <= DATA_RST;
      end
      else
      begin
         done_seen_reg <= done_tgl_s;
         done_pulse_reg <= done_evt;
         if (done_evt)
            rd_data_reg <= rdata_hold_reg;
      end
   end

   // ----------------------------------------------------------------
   // Link side: half-tick sequencer
   // ----------------------------------------------------------------
   logic lrst_n;
   logic req_tgl_s;
   logic req_seen_reg;
   logic wait_s;
   logic [1:0] wait_dly_reg;
   logic [DATA_W-1:0] pdin_s;
   logic sdin_s;
   apat_state_e state_reg, state_next;
   logic [PT_W-1:0] t_reg;
   logic [BIT_W-1:0] bit_reg;
   logic [1:0] gap_reg;
   logic [DATA_W-1:0] shift_reg;
   logic new_req, start, bit_end, serial, last_bit, finish, sample_now;
   logic cs_win, rs_win, st_win, frame_win, running;
   logic cs_o, rs_o, rd_o, wr_o, sclk_o, srs_o, soe_o, poe_o;

   // Link reset asserts at once and releases on the link clock
   apat_sync #(.W(1)) u_lrst (.clk(panel_port_clock), .rst_n(rst_n), .d(1'b1), .q(lrst_n));
   apat_sync #(.W(1)) u_req_sync (.clk(panel_port_clock), .rst_n(lrst_n), .d(req_tgl_reg),
      .q(req_tgl_s));
   apat_sync #(.W(1)) u_wait_sync (.clk(panel_port_clock), .rst_n(lrst_n), .d(panel_wait),
      .q(wait_s));
   apat_sync #(.W(DATA_W)) u_pd_sync (.clk(panel_port_clock), .rst_n(lrst_n),
      .d(par_data_in), .q(pdin_s));
   apat_sync #(.W(1)) u_sd_sync (.clk(panel_port_clock), .rst_n(lrst_n), .d(serial_data_in),
      .q(sdin_s));

   // Sequencing terms
   // serial variants
   assign serial = (mode_reg != APAT_PAR80) && (mode_reg != APAT_PAR68);
   assign new_req = req_tgl_s ^ req_seen_reg;
   assign start = (state_reg == APAT_IDLE) && new_req && !wait_dly_reg[1];
   assign bit_end = (state_reg == APAT_RUN) && (t_reg == size_reg - 10'h001);
   assign last_bit = !serial || (bit_reg == SER_BIT_LAST);
   assign finish = bit_end && last_bit;
   assign sample_now = (state_reg == APAT_RUN) && read_reg && (t_reg == smp_reg);
   assign running = (state_reg == APAT_RUN);

   assign st_win = (t_reg >= st_up_reg) && (t_reg < st_dn_reg);
   assign frame_win = ((bit_reg != '0) || (t_reg >= cs_up_reg))
      && (!last_bit || (t_reg < cs_dn_reg));
   assign cs_win = serial ? frame_win : ((t_reg >= cs_up_reg) && (t_reg < cs_dn_reg));
   assign rs_win = (mode_reg == APAT_SER5B) ? frame_win
      : ((t_reg >= rs_up_reg) && (t_reg < rs_dn_reg));

   // Pin levels before the output registers
   assign cs_o = running && cs_win;
   assign rs_o = running && !serial && rs_win && rs_val_reg;
   assign rd_o = running && !serial && st_win && ((mode_reg == APAT_PAR68) || read_reg);
   assign wr_o = running && !serial && ((mode_reg == APAT_PAR68) ? read_reg
      : (st_win && !read_reg));
   assign poe_o = running && !serial && !read_reg;
   assign sclk_o = running && serial && st_win;
   assign srs_o = running && rs_win && rs_val_reg
      && ((mode_reg == APAT_SER5A) || (mode_reg == APAT_SER5B));
   assign soe_o = running && (mode_reg == APAT_SER3) && !read_reg;

   // Next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         APAT_IDLE: if (start) state_next = APAT_RUN;
         APAT_RUN: if (finish) state_next = single_reg ? APAT_GAP : APAT_IDLE;
         APAT_GAP: if (gap_reg == 2'h1) state_next = APAT_IDLE;
      endcase
   end

   // Counters and state
   always_ff @(posedge panel_port_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         state_reg <= APAT_IDLE;
         t_reg <= PT_RST;
         bit_reg <= '0;
         gap_reg <= 2'h0;
         req_seen_reg <= 1'b0;
         wait_dly_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         wait_dly_reg <= {wait_dly_reg[0], wait_s};
         if (start)
            req_seen_reg <= req_tgl_s;
         t_reg <= (!running || bit_end) ? PT_RST : t_reg + 10'h001;
         if (start)
            bit_reg <= '0;
         else if (bit_end)
            bit_reg <= bit_reg + 3'h1;
         gap_reg <= (finish && single_reg) ? GAP_TICKS
            : ((gap_reg != 2'h0) ? gap_reg - 2'h1 : gap_reg);
      end
   end

   // Data shifting, answer hold and its toggle
   always_ff @(posedge panel_port_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         shift_reg <= DATA_RST;
         rdata_hold_reg <= DATA_RST;
         done_tgl_reg <= 1'b0;
      end
      else
      begin
         if (start)
            shift_reg <= wdata_reg;
         else if (sample_now)
            shift_reg <= serial ? {shift_reg[DATA_W-2:0], sdin_s} : pdin_s;
         else if (bit_end && serial && !read_reg)
            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
         if (finish)
         begin
            rdata_hold_reg <= shift_reg;
            done_tgl_reg <= !done_tgl_reg;
         end
      end
   end

   always_ff @(posedge panel_port_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         panel_chip_select <= 1'b0;
         register_select <= 1'b0;
         panel_rd_strobe <= 1'b0;
         panel_wr_strobe <= 1'b0;
         par_data_out <= DATA_RST;
         par_data_oe <= 1'b0;
         serial_panel_clock <= 1'b0;
         serial_data_out <= 1'b0;
         serial_out_enable <= 1'b0;
         serial_register_select <= 1'b0;
      end
      else
      begin
         panel_chip_select <= cs_o;
         register_select <= rs_o;
         panel_rd_strobe <= rd_o;
         panel_wr_strobe <= wr_o;
         par_data_out <= wdata_reg;
         par_data_oe <= poe_o;
         serial_panel_clock <= sclk_o;
         serial_data_out <= running && serial && !read_reg && shift_reg[DATA_W-1];
         serial_out_enable <= soe_o;
         serial_register_select <= srs_o;
      end
   end

   // ----------------------------------------------------------------
   // Checks on the link side
   // ----------------------------------------------------------------
   default clocking cb @(posedge panel_port_clock); endclocking
   default disable iff (!lrst_n);

   sequence gap_two_s;
      (state_reg == APAT_GAP) [*2] ##1 (state_reg == APAT_IDLE);
   endsequence
   sequence strobes_off_s;
      !panel_chip_select && !panel_rd_strobe && !panel_wr_strobe && !serial_panel_clock;
   endsequence

   access_len_a: assert property (start |-> ##1 running [*2])
      else $error("access shorter than two half ticks");
   access_end_a: assert property (running |-> t_reg < size_reg)
      else $error("half tick count beyond access size");
   cs_window_a: assert property (running && !serial |=>
      panel_chip_select == ($past(t_reg) >= cs_up_reg && $past(t_reg) < cs_dn_reg))
      else $error("chip select off its window");
   rd_wr_excl_a: assert property (mode_reg == APAT_PAR80 |->
      !(panel_rd_strobe && panel_wr_strobe))
      else $error("read and write strobes together");
   gap_idle_a: assert property (finish && single_reg |=> gap_two_s)
      else $error("single access gap not two half ticks");
   gap_quiet_a: assert property (state_reg == APAT_GAP && $past(state_reg) == APAT_GAP
      |-> strobes_off_s)
      else $error("strobe active in gap");
   wait_hold_a: assert property (wait_dly_reg[1] && state_reg == APAT_IDLE |=>
      state_reg != APAT_RUN)
      else $error("access began under wait");
   wait_delay_a: assert property ($rose(wait_s) |-> ##2 wait_dly_reg[1])
      else $error("wait reaction not two half ticks");
   oe_write_a: assert property (serial_out_enable |-> $past(!read_reg)
      && $past(mode_reg == APAT_SER3))
      else $error("output enable outside 3-wire write");
   done_tgl_a: assert property (finish |=> done_tgl_reg != $past(done_tgl_reg))
      else $error("finish without answer toggle");
endmodule // apat_top
`default_nettype wire

// ---- test/apat_panel.sv ----
// Behavioural display panel model for the parallel and serial panel pins
`default_nettype none
module apat_panel
(
   // Panel side pins
   input wire logic panel_chip_select,
   input wire logic serial_panel_clock,
   input wire logic serial_data_out,
   input wire logic serial_out_enable,
   // Stimulus and capture
   input wire logic [apat_pkg::DATA_W-1:0] rd_byte,
   output logic [apat_pkg::DATA_W-1:0] par_data_in,
   output logic serial_data_in,
   output logic [apat_pkg::DATA_W-1:0] wr_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sd_reg = 1'b0;
   int idx = 7;
   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // data valid while selected
   assign par_data_in = panel_chip_select ? rd_byte : ~rd_byte;
   // Shared 3-wire line follows whoever drives it
   assign serial_data_in = serial_out_enable ? serial_data_out : sd_reg;
   always @(posedge panel_chip_select)
   begin
      idx = 7;
      sd_reg = rd_byte[7];
   end
   // Next bit after each falling clock, MSB first
   always @(negedge serial_panel_clock)
   begin
      idx = idx - 1;
      if (panel_chip_select && idx >= 0)
         sd_reg = rd_byte[idx];
   end
   // Released line shows the inverse, never a stale value
   always @(negedge panel_chip_select)
      sd_reg = ~sd_reg;
   // Write bits captured on the rising serial clock
   initial wr_byte = 8'h00;
   always @(posedge serial_panel_clock)
      wr_byte = {wr_byte[6:0], serial_data_out};
endmodule // apat_panel
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the panel access timing generator
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import apat_pkg::*;
   localparam int P = 3;
   logic clock, rst_n, link_clk, single_mode, wait_in;
   apat_mode_e bus_mode;
   apat_mode_e smodes [4] = '{APAT_SER3, APAT_SER4, APAT_SER5A, APAT_SER5B};
   logic req_valid, req_ready, req_is_read, req_rs_value, done_pulse;
   logic [DATA_W-1:0] req_wdata, rd_data, pdo, pdi, rd_byte, wr_byte, pd_seen;
   logic [DATA_W-1:0] period, wr_size, rd_size, cs_up, cs_dn, rs_up, rs_dn, smp_op;
   logic cs, rs, rd_s, wr_s, pdoe, sclk, sdo, soe, srs, sdi;
   logic [7:0] pins;
   int n_fail, n_compared, cycles, lcnt;
   int hi[8], rise[8];
   assign pins = {pdoe, srs, soe, sclk, wr_s, rd_s, rs, cs};
   // ----------------------------------------------------------------
   // Design, panel and clocks
   // ----------------------------------------------------------------
   apat_top uut (.clock(clock), .rst_n(rst_n), .panel_port_clock(link_clk),
      .bus_mode(bus_mode), .single_access_mode(single_mode), .clock_period_setting(period),
      .write_access_size(wr_size), .read_access_size(rd_size), .cs_assert_point(cs_up),
      .cs_release_point(cs_dn), .rs_assert_point(rs_up), .rs_release_point(rs_dn),
      .rd_assert_point(8'h01), .rd_release_point(8'h08), .wr_assert_point(8'h01),
      .wr_release_point(8'h08), .read_sample_operand(smp_op), .req_valid(req_valid),
      .req_ready(req_ready), .req_is_read(req_is_read), .req_rs_value(req_rs_value),
      .req_wdata(req_wdata), .done_pulse(done_pulse), .rd_data(rd_data),
      .panel_chip_select(cs), .register_select(rs), .panel_rd_strobe(rd_s),
      .panel_wr_strobe(wr_s), .par_data_out(pdo), .par_data_oe(pdoe), .par_data_in(pdi),
      .panel_wait(wait_in), .serial_panel_clock(sclk), .serial_data_out(sdo),
      .serial_out_enable(soe), .serial_register_select(srs), .serial_data_in(sdi));
   apat_panel panel (.panel_chip_select(cs), .serial_panel_clock(sclk),
      .serial_data_out(sdo), .serial_out_enable(soe), .rd_byte(rd_byte),
      .par_data_in(pdi), .serial_data_in(sdi), .wr_byte(wr_byte));
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Odd offset keeps link edges off every system clock edge
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end
   // ----------------------------------------------------------------
   // Link side monitor: high time and first rise of every select, strobe, clock and enable pin
   // ----------------------------------------------------------------
   always @(posedge link_clk)
   begin
      lcnt++;
      for (int i = 0; i < 8; i++)
         if (pins[i] === 1'b1)
         begin
            hi[i]++;
            if (rise[i] < 0)
               rise[i] = lcnt;
         end
      if (wr_s === 1'b1 && pdoe === 1'b1)
         pd_seen = pdo;
   end
   // Hang guard, far above the expected run length
   always @(posedge clock)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         n_fail++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------
   function automatic int half(int v);
      return (2 * v + P - 1) / P;
   endfunction
   // Whole interface clocks, counted in half ticks
   function automatic int full(int v);
      return 2 * ((v + P - 1) / P);
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic access(apat_mode_e m, logic r, logic rsv, logic [7:0] wd);
      int k;
      @(negedge clock);
      for (int i = 0; i < 8; i++)
      begin
         hi[i] = 0;
         rise[i] = -1;
      end
      bus_mode = m;
      req_is_read = r;
      req_rs_value = rsv;
      req_wdata = wd;
      req_valid = 1'b1;
      k = 0;
      // Ready is read while settled, then one rising edge takes the request
      while (req_ready !== 1'b1 && k < 100)
      begin
         @(negedge clock);
         k++;
      end
      @(posedge clock);
      @(negedge clock);
      req_valid = 1'b0;
      k = 0;
      while (done_pulse !== 1'b1 && k < 2000)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      check("done", done_pulse, 1'b1);
      @(negedge clock);
   endtask
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      single_mode = 1'b0;
      wait_in = 1'b0;
      bus_mode = APAT_PAR80;
      {req_valid, req_is_read, req_rs_value} = 3'h0;
      req_wdata = 8'h00;
      rd_byte = 8'h3c;
      {period, wr_size, rd_size} = {8'h03, 8'h0c, 8'h0c};
      {cs_up, cs_dn, rs_up, rs_dn, smp_op} = {8'h00, 8'h09, 8'h02, 8'h07, 8'h07};
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      access(APAT_PAR80, 1'b0, 1'b1, 8'ha5);
      check("cs width", hi[0], half(9) - half(0));
      check("rs offset", rise[1] - rise[0], half(2));
      check("rs width", hi[1], half(7) - half(2));
      check("wr offset", rise[3] - rise[0], half(1));
      check("wr width", hi[3], half(8) - half(1));
      check("rd idle", hi[2], 0);
      check("write word", pd_seen, 8'ha5);
      check("oe par write", hi[7], full(12));
      access(APAT_PAR80, 1'b1, 1'b0, 8'h00);
      check("rd offset", rise[2] - rise[0], half(1));
      check("rd width", hi[2], half(8) - half(1));
      check("rs low", hi[1], 0);
      check("read word", rd_data, 8'h3c);
      check("oe par read", hi[7], 0);
      rd_byte = 8'hc3;
      // Read size now differs from write size
      rd_size = 8'h10;
      access(APAT_PAR68, 1'b1, 1'b0, 8'h00);
      check("enable width", hi[2], half(8) - half(1));
      check("rw level", hi[3], full(16));
      check("read68 word", rd_data, 8'hc3);
      access(APAT_PAR68, 1'b0, 1'b0, 8'h69);
      check("rw write", hi[3], 0);
      check("e write", hi[2], half(8) - half(1));
      check("oe 68 write", hi[7], full(12));
      single_mode = 1'b1;
      rd_byte = 8'h5a;
      for (int i = 0; i < 4; i++)
      begin
         access(smodes[i], 1'b0, 1'b1, 8'h96);
         check("serial word", wr_byte, 8'h96);
         check("frame width", hi[0], 7 * 8 + half(9) - half(0));
         check("sclk width", hi[4], 8 * (half(8) - half(1)));
         check("oe use", hi[5] > 0, smodes[i] == APAT_SER3);
         check("srs width", hi[6], smodes[i] == APAT_SER5A ? 24 :
            smodes[i] == APAT_SER5B ? 62 : 0);
         access(smodes[i], 1'b1, 1'b0, 8'h00);
         check("serial read", rd_data, 8'h5a);
         check("oe on read", hi[5], 0);
      end
      wait_in = 1'b1;
      fork
         access(APAT_PAR80, 1'b0, 1'b0, 8'h11);
         begin
            repeat (60) @(negedge clock);
            check("held off", hi[0], 0);
            wait_in = 1'b0;
         end
      join
      check("after wait", hi[0], half(9) - half(0));
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
